// ===== wlf_pkg.sv
// Package with constants and types for the write leveling feedback block.
package wlf_pkg;
    localparam int CLK_MHZ           = 100;
    localparam int DQ_W              = 16;
    localparam int LANES             = 2;
    localparam int MR1_WL_BIT        = 7;
    localparam int MR1_QOFF_BIT      = 12;
    localparam int MR1_RTT_BIT0      = 3;
    localparam int MR1_RTT_BIT1      = 6;
    localparam int MR1_RTT_BIT2      = 9;
    localparam int LANE_PRIME_OFS    = 0;
    localparam int UPPER_PRIME_POS   = 8;
    localparam int TMOD_NS           = 120;
    localparam int TMOD_CYC          = (TMOD_NS * CLK_MHZ + 999) / 1000;
    localparam int TWLO_NS           = 20;
    localparam int TWLO_CYC          = ((TWLO_NS * CLK_MHZ) / 1000 < 1) ? 1 :
                                       (TWLO_NS * CLK_MHZ) / 1000;
    localparam int TWLOE_NS          = 20;
    localparam int TWLOE_CYC         = ((TWLOE_NS * CLK_MHZ) / 1000 < 1) ? 1 :
                                       (TWLOE_NS * CLK_MHZ) / 1000;
    localparam logic [15:0] MR1_RST  = 16'h0000;
    localparam logic [3:0]  ADR_MR1  = 4'h0;
    localparam logic [3:0]  ADR_STAT = 4'h4;
    localparam logic [3:0]  ADR_X16  = 4'h8;
    typedef enum {WLF_OFF, WLF_SETTLE, WLF_ON, WLF_EXIT} wlf_mode_type;
endpackage : wlf_pkg

// ===== wlf_sync.sv
// Three-flop input synchroniser that reports a level once the last two agree.
`timescale 1ns/100ps
`default_nettype none
module wlf_sync (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic d_i,
    output logic      q_o,
    output logic      rise_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
        logic rise;
    } wlf_sync_type;
    wlf_sync_type st_r;
    wlf_sync_type st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.s1   = d_i;
        st_nxt.s2   = st_r.s1;
        st_nxt.s3   = st_r.s2;
        st_nxt.rise = 1'b0;
        if (st_r.s2 == st_r.s3) begin
            st_nxt.q    = st_r.s3;
            st_nxt.rise = st_r.s3 & ~st_r.q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q_o    = st_r.q;
    assign rise_o = st_r.rise;
endmodule : wlf_sync
`default_nettype wire

// ===== wlf_lane.sv
// One byte lane of leveling feedback: samples the clock on strobe rises.
`timescale 1ns/100ps
`default_nettype none
module wlf_lane (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic active_i,
    input  wire logic strobe_rise_i,
    input  wire logic ck_level_i,
    output logic      prime_o,
    output logic      first_o
);
    typedef struct packed {
        logic prime;
        logic seen;
        logic first;
    } wlf_lane_type;
    wlf_lane_type st_r;
    wlf_lane_type st_nxt;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.first = 1'b0;
        if (!active_i) begin
            st_nxt = '0;
        end else if (strobe_rise_i) begin
            st_nxt.prime = ck_level_i;
            st_nxt.first = ~st_r.seen;
            st_nxt.seen  = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prime_o = st_r.prime;
    assign first_o = st_r.first;
endmodule : wlf_lane
`default_nettype wire

// ===== wlf_top.sv
// Device-side write leveling feedback with a classic Wishbone register slave.
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module wlf_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        ck_i,
    input  wire logic        strobe_lo_i,
    input  wire logic        strobe_hi_i,
    input  wire logic        odt_i,
    output logic      [15:0] dq_o,
    output logic      [15:0] dq_oe_o,
    output logic      [1:0]  strobe_term_o,
    output logic             dq_term_o,
    output logic             leveling_o
);
    typedef struct packed {
        logic [15:0]          mr1;
        logic                 x16;
        wlf_pkg::wlf_mode_type mode;
        logic [7:0]           tmr;
        logic [15:0]          dq;
        logic [15:0]          dq_oe;
        logic [1:0]           term;
        logic                 lvl;
        logic                 ack;
        logic [31:0]          rdat;
        logic [1:0]           first_seen;
        logic [7:0]           oe_tmr;
    } wlf_top_type;
    wlf_top_type st_r;
    wlf_top_type st_nxt;

    logic ck_s;
    logic odt_s;
    logic [1:0] strobe_s;
    logic [1:0] strobe_rise;
    logic [1:0] prime;
    logic [1:0] first;
    logic active;
    logic unused_rise;

    wlf_sync u_ck (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .d_i    (ck_i),
        .q_o    (ck_s),
        .rise_o (unused_rise)
    );
    wlf_sync u_odt (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .d_i    (odt_i),
        .q_o    (odt_s),
        .rise_o ()
    );

    // Output buffer disable also makes the strobes ignore their input.
    assign active = (st_r.mode == wlf_pkg::WLF_ON) & ~st_r.mr1[wlf_pkg::MR1_QOFF_BIT];

    genvar g;
    generate
        for (g = 0; g < wlf_pkg::LANES; g++) begin : g_lane
            wlf_sync u_stb (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .d_i    (g == 0 ? strobe_lo_i : strobe_hi_i),
                .q_o    (strobe_s[g]),
                .rise_o (strobe_rise[g])
            );
            wlf_lane u_lane (
                .clk_i         (clk_i),
                .rst_i         (rst_i),
                .active_i      (active & ((g == 0) | st_r.x16)),
                .strobe_rise_i (strobe_rise[g]),
                .ck_level_i    (ck_s),
                .prime_o       (prime[g]),
                .first_o       (first[g])
            );
        end
    endgenerate

    always_comb begin
        st_nxt     = st_r;
        st_nxt.ack = 1'b0;
        // Wishbone classic: one wait state, ack dropped the cycle after.
        if (wb_cyc_i && wb_stb_i && !st_r.ack) begin
            st_nxt.ack = 1'b1;
            case (wb_adr_i)
                wlf_pkg::ADR_MR1:  st_nxt.rdat = {16'h0000, st_r.mr1};
                wlf_pkg::ADR_STAT: st_nxt.rdat = {27'h0000000, prime, st_r.term[0],
                                                  st_r.lvl, active};
                wlf_pkg::ADR_X16:  st_nxt.rdat = {31'h00000000, st_r.x16};
                default:           st_nxt.rdat = 32'h00000000;
            endcase
            if (wb_we_i) begin
                case (wb_adr_i)
                    wlf_pkg::ADR_MR1: begin
                        if (wb_sel_i[0]) begin
                            st_nxt.mr1[7:0] = wb_dat_i[7:0];
                        end
                        if (wb_sel_i[1]) begin
                            st_nxt.mr1[15:8] = wb_dat_i[15:8];
                        end
                        // A mode write restarts the settling delay only when tmr has run out; a running count keeps going.
                        st_nxt.tmr = 8'(wlf_pkg::TMOD_CYC);
                        if ((wb_sel_i[0] ? wb_dat_i[wlf_pkg::MR1_WL_BIT]
                                         : st_r.mr1[wlf_pkg::MR1_WL_BIT])) begin
                            st_nxt.mode = wlf_pkg::WLF_SETTLE;
                        end else if (st_r.mode != wlf_pkg::WLF_OFF) begin
                            st_nxt.mode = wlf_pkg::WLF_EXIT;
                        end
                    end
                    wlf_pkg::ADR_X16: begin
                        if (wb_sel_i[0]) begin
                            st_nxt.x16 = wb_dat_i[0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        if (st_r.tmr != 8'h00) begin
            st_nxt.tmr = st_r.tmr - 8'h01;
        end
        case (st_r.mode)
            wlf_pkg::WLF_SETTLE: begin
                if (st_r.tmr == 8'h00 && st_nxt.mode == wlf_pkg::WLF_SETTLE) begin
                    st_nxt.mode = wlf_pkg::WLF_ON;
                end
            end
            wlf_pkg::WLF_EXIT: begin
                if (st_r.tmr == 8'h00 && st_nxt.mode == wlf_pkg::WLF_EXIT) begin
                    st_nxt.mode = wlf_pkg::WLF_OFF;
                end
            end
            default: begin
            end
        endcase

        st_nxt.lvl   = (st_nxt.mode != wlf_pkg::WLF_OFF);
        // Termination follows the pin on the strobes (upper strobe in x16 only) in WLF_ON only; data lines stay open.
        st_nxt.term  = (st_r.mode == wlf_pkg::WLF_ON) ?
                       {odt_s & st_r.x16, odt_s} : 2'b00;

        if (!active) begin
            st_nxt.first_seen = 2'b00;
            st_nxt.oe_tmr     = 8'h00;
        end else begin
            st_nxt.first_seen = st_r.first_seen | first;
            if (first[0] && st_r.first_seen == 2'b00) begin
                st_nxt.oe_tmr = 8'(wlf_pkg::TWLOE_CYC);
            end else if (st_r.oe_tmr != 8'h00) begin
                st_nxt.oe_tmr = st_r.oe_tmr - 8'h01;
            end
        end

        // Outside the driven window every data line is released, except during exit:
        // with outputs enabled the lower byte (all 16 lines in x16) stays driven and holds its last value.
        st_nxt.dq    = 16'h0000;
        st_nxt.dq_oe = 16'h0000;
        if (active) begin
            st_nxt.dq_oe = 16'hffff;
            st_nxt.dq[0] = prime[0];
            if (st_r.x16) begin
                st_nxt.dq[wlf_pkg::UPPER_PRIME_POS] = prime[1];
            end else begin
                st_nxt.dq_oe[15:8] = 8'h00;
            end
        end else if (st_r.mode == wlf_pkg::WLF_EXIT &&
                     !st_r.mr1[wlf_pkg::MR1_QOFF_BIT]) begin
            st_nxt.dq_oe = st_r.x16 ? 16'hffff : 16'h00ff;
            st_nxt.dq    = st_r.dq;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r      <= '0;
            st_r.mr1  <= wlf_pkg::MR1_RST;
            st_r.mode <= wlf_pkg::WLF_OFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_dat_o      = st_r.rdat;
    assign wb_ack_o      = st_r.ack;
    assign dq_o          = st_r.dq;
    assign dq_oe_o       = st_r.dq_oe;
    assign strobe_term_o = st_r.term;
    assign dq_term_o     = 1'b0;
    assign leveling_o    = st_r.lvl;

    feedback_follows_a: assert property (@(posedge clk_i) disable iff (rst_i)
        active && strobe_rise[0] ##1 active |-> ##1 dq_o[0] == $past(ck_s, 2))
        else $error("prime line did not follow sampled clock");
    others_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
        dq_oe_o[0] |-> dq_o[7:1] == 7'h00 && dq_o[15:9] == 7'h00)
        else $error("non-prime data line driven high");
    upper_lane_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !st_r.x16 && active |=> dq_o[8] == 1'b0)
        else $error("upper prime driven in narrow mode");
    entry_settle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(leveling_o) |-> !active [*8])
        else $error("feedback started before settling delay");
    qoff_hiz_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_r.mr1[wlf_pkg::MR1_QOFF_BIT] |=> dq_oe_o == 16'h0000)
        else $error("outputs driven with buffers disabled");
    dq_unterm_a: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |-> dq_term_o == 1'b0 && (leveling_o || strobe_term_o == 2'b00))
        else $error("termination applied outside strobes");
    fb_latency_a: assert property (@(posedge clk_i) disable iff (rst_i)
        active && strobe_rise[0] && $stable(ck_s) ##1 active |->
        ##[1:2] dq_o[0] == $past(ck_s))
        else $error("feedback late");
    exit_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_r.mode == wlf_pkg::WLF_OFF |=> dq_oe_o == 16'h0000)
        else $error("data lines driven after exit settled");
    ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    enter_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(active));
    sample_one_c: cover property (@(posedge clk_i) disable iff (rst_i)
        active && $rose(dq_o[0]));
    upper_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(dq_o[8]));
    exit_c: cover property (@(posedge clk_i) disable iff (rst_i) $fell(leveling_o));
endmodule : wlf_top
`default_nettype wire

// ===== wlf_ctrl_model.sv
// Controller-side model: makes the DRAM clock level and delayed leveling strobe pulses.
`timescale 1ns/100ps
`default_nettype none
module wlf_ctrl_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       go_i,
    input  wire logic [4:0] phase_i,
    output logic            ck_o,
    output logic            strobe_o,
    output logic            busy_o
);
    logic [4:0] cnt_r;
    logic [3:0] pw_r;
    // No command port exists, so only idle cycles reach the device while leveling.
    // The strobe rests low between pulses and no data line is ever driven here.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r    <= 5'h00;
            ck_o     <= 1'b0;
            strobe_o <= 1'b0;
            busy_o   <= 1'b0;
            pw_r     <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 5'h01;
            ck_o  <= ~cnt_r[4];
            if (go_i && !busy_o) begin
                busy_o <= 1'b1;
            end
            if (busy_o && pw_r == 4'h0 && cnt_r == phase_i) begin
                strobe_o <= 1'b1;
                pw_r     <= 4'h8;
            end else if (pw_r != 4'h0) begin
                pw_r <= pw_r - 4'h1;
                // Four cycles high and four low keep both minimum widths.
                if (pw_r == 4'h5) strobe_o <= 1'b0;
                // Busy holds until the feedback of the last rise can settle.
                if (pw_r == 4'h1) busy_o <= 1'b0;
            end
        end
    end
endmodule : wlf_ctrl_model
`default_nettype wire

// ===== tb_write_leveling_feedback.sv
// Self-checking bench for the write leveling feedback block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_write_leveling_feedback;
    logic        clk, rst, cyc, stb, we, ack, odt, ck, s_lo, s_hi, b_lo, b_hi, dterm, lev;
    logic        go_lo, go_hi;
    logic [4:0]  ph_lo, ph_hi;
    logic [3:0]  adr, sel;
    logic [31:0] wdat, rdat, q;
    logic [15:0] dq, dq_oe;
    logic [1:0]  sterm;
    int          fail_count, total_checks;

    wlf_top wlf_top_inst (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .ck_i(ck), .strobe_lo_i(s_lo), .strobe_hi_i(s_hi), .odt_i(odt),
        .dq_o(dq), .dq_oe_o(dq_oe), .strobe_term_o(sterm), .dq_term_o(dterm),
        .leveling_o(lev));
    wlf_ctrl_model wlf_ctrl_model_inst (.clk_i(clk), .rst_i(rst), .go_i(go_lo),
        .phase_i(ph_lo), .ck_o(ck), .strobe_o(s_lo), .busy_o(b_lo));
    wlf_ctrl_model wlf_ctrl_model_hi_inst (.clk_i(clk), .rst_i(rst), .go_i(go_hi),
        .phase_i(ph_hi), .ck_o(), .strobe_o(s_hi), .busy_o(b_hi));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic give_up;
        fail_count++;
        $display("wait limit ran out at t=%0t", $time);
        tally_and_finish();
    endtask : give_up

    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
    endtask : ticks

    // Classic single cycle; request held until ack is sampled high.
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int n;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= 4'h3;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) give_up();
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    task automatic pulse(input logic gl, input logic gh, input logic [4:0] pl,
                         input logic [4:0] phh);
        int n;
        @(posedge clk);
        ph_lo <= pl;
        ph_hi <= phh;
        go_lo <= gl;
        go_hi <= gh;
        @(posedge clk);
        go_lo <= 1'b0;
        go_hi <= 1'b0;
        // Busy is launched at the edge that takes go, so let one more edge pass.
        @(posedge clk);
        n = 0;
        while ((b_lo === 1'b1 || b_hi === 1'b1) && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100) give_up();
        ticks(8);
    endtask : pulse

    task automatic t_reset;
        `CHK(lev, 1'b0)
        `CHK(dq_oe, 16'h0000)
        wb(1'b0, wlf_pkg::ADR_MR1, 32'h0, q);
        `CHK(q[15:0], wlf_pkg::MR1_RST)
        wb(1'b0, 4'hc, 32'h0, q);
        `CHK(q, 32'h0000_0000)
        $display("test reset done");
    endtask : t_reset

    task automatic t_enter;
        wb(1'b1, wlf_pkg::ADR_MR1, 32'h0000_0080, q);
        wb(1'b0, wlf_pkg::ADR_STAT, 32'h0, q);
        `CHK(q[1:0], 2'b10)
        ticks(wlf_pkg::TMOD_CYC + 2);
        wb(1'b0, wlf_pkg::ADR_STAT, 32'h0, q);
        `CHK(q[0], 1'b1)
        `CHK(dq_oe, 16'h00ff)
        $display("test enter done");
    endtask : t_enter

    task automatic t_sweep;
        logic [4:0] ph [5] = '{5'h14, 5'h18, 5'h1c, 5'h04, 5'h08};
        logic       ex [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        logic       prev;
        int         found;
        prev  = 1'b1;
        found = -1;
        for (int i = 0; i < 5; i++) begin
            pulse(1'b1, 1'b0, ph[i], 5'h00);
            `CHK(dq[0], ex[i])
            `CHK(dq[7:1], 7'h00)
            if (prev === 1'b0 && dq[0] === 1'b1 && found < 0) found = i;
            prev = dq[0];
        end
        `CHK(found, 3)
        $display("test sweep done");
    endtask : t_sweep

    task automatic t_odt;
        @(posedge clk);
        odt <= 1'b1;
        ticks(8);
        `CHK(sterm[0], 1'b1)
        `CHK(dterm, 1'b0)
        odt <= 1'b0;
        ticks(8);
        `CHK(sterm[0], 1'b0)
        $display("test odt done");
    endtask : t_odt

    task automatic t_x16;
        wb(1'b1, wlf_pkg::ADR_X16, 32'h1, q);
        pulse(1'b1, 1'b1, 5'h08, 5'h18);
        `CHK(dq, 16'h0001)
        `CHK(dq_oe, 16'hffff)
        pulse(1'b1, 1'b1, 5'h18, 5'h08);
        `CHK(dq, 16'h0100)
        wb(1'b1, wlf_pkg::ADR_X16, 32'h0, q);
        $display("test x16 done");
    endtask : t_x16

    task automatic t_qoff;
        wb(1'b1, wlf_pkg::ADR_MR1, 32'h0000_1080, q);
        ticks(wlf_pkg::TMOD_CYC + 2);
        `CHK(dq_oe, 16'h0000)
        pulse(1'b1, 1'b0, 5'h08, 5'h00);
        `CHK(dq_oe, 16'h0000)
        wb(1'b0, wlf_pkg::ADR_STAT, 32'h0, q);
        `CHK(q[0], 1'b0)
        $display("test outputs off done");
    endtask : t_qoff

    task automatic t_exit;
        wb(1'b1, wlf_pkg::ADR_MR1, 32'h0000_0080, q);
        ticks(wlf_pkg::TMOD_CYC + 2);
        pulse(1'b1, 1'b0, 5'h08, 5'h00);
        wb(1'b1, wlf_pkg::ADR_MR1, 32'h0, q);
        ticks(4);
        `CHK(lev, 1'b1)
        `CHK(dq_oe, 16'h00ff)
        ticks(wlf_pkg::TMOD_CYC);
        `CHK(lev, 1'b0)
        `CHK(dq_oe, 16'h0000)
        $display("test exit done");
    endtask : t_exit

    initial begin
        {rst, cyc, stb, we, odt, go_lo, go_hi} = 7'h7f & 7'h40;
        {adr, sel, wdat, ph_lo, ph_hi} = '0;
        fail_count   = 0;
        total_checks = 0;
        ticks(12);
        rst <= 1'b0;
        t_reset();
        t_enter();
        t_sweep();
        t_odt();
        t_x16();
        t_qoff();
        t_exit();
        tally_and_finish();
    end
endmodule : tb_write_leveling_feedback
`default_nettype wire
